// ==== rtl/hhsd_defs.svh ====
`ifndef HHSD_DEFS_SVH
`define HHSD_DEFS_SVH
// ==========================================================
// register offsets (byte addresses, word aligned)
`define HHSD_OFS_CMD      8'h00
`define HHSD_OFS_STS      8'h04
`define HHSD_OFS_IEN      8'h08
`define HHSD_OFS_ALP      8'h0C
`define HHSD_OFS_PFB      8'h10
// ==========================================================
// host_command fields
`define HHSD_CMD_DB       6
`define HHSD_CMD_ASE      5
`define HHSD_CMD_PSE      4
`define HHSD_CMD_ITC_LO   16
`define HHSD_CMD_ITC_HI   23
`define HHSD_ITC_RST      8'h08
// ==========================================================
// host_status / host_irq_enable fields
`define HHSD_STS_AAF      5
// ==========================================================
// pointer alignment masks
`define HHSD_ALP_MASK     32'hFFFF_FFE0
`define HHSD_PFB_MASK     32'hFFFF_F000
// ==========================================================
// timing
`define HHSD_CLK_NS       50
`define HHSD_UFRAME_NS    125000
`define HHSD_UFRAME_CYC   ((`HHSD_UFRAME_NS + `HHSD_CLK_NS - 1) / `HHSD_CLK_NS)
`endif

// ==== rtl/hhsd_pkg.sv ====
`default_nettype none
package hhsd_pkg;
  typedef enum logic [1:0] {
    DB_IDLE,
    DB_FLUSH,
    DB_CLEAR
  } hhsd_db_e;

  typedef struct packed {
    logic        async_en;
    logic        periodic_en;
    logic [31:0] async_addr;
    logic [31:0] periodic_base;
  } hhsd_sched_s;
endpackage
`default_nettype wire

// ==== rtl/hhsd_top.sv ====
// How it works
// - after cached schedule state is evicted, set the async-advance status flag
// - enabled async-advance interrupt is raised at next threshold boundary only
// - controller clears the doorbell itself, only after the flag is set
// - async enable at bit 5 resets to 0; zero skips async processing
// - async enable high: fetch async schedule from async list pointer
// - periodic enable at bit 4 resets to 0; zero skips periodic processing
// - periodic enable high: use periodic frame list base for periodic schedule
// - threshold in micro frames, default eight; interrupts only at boundaries
`timescale 1ns/10ps
`default_nettype none
`include "hhsd_defs.svh"

module hhsd_top
  import hhsd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        evict_done_i,
  output logic             flush_req_o,
  output var hhsd_sched_s  sched_o,
  output logic             irq_o
);
  // ==========================================================
  // bus decode
  logic [31:0] wmask;
  logic        acc;
  logic        wr;
  logic        wr_cmd;
  logic        wr_sts;
  logic        wr_ien;
  logic        wr_alp;
  logic        wr_pfb;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_data;

  assign wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign acc    = cyc_i & stb_i;
  // writes land on the edge where ack is seen, as the master expects
  assign wr     = acc & we_i & ack_r;
  assign wr_cmd = wr & (adr_i == `HHSD_OFS_CMD);
  assign wr_sts = wr & (adr_i == `HHSD_OFS_STS);
  assign wr_ien = wr & (adr_i == `HHSD_OFS_IEN);
  assign wr_alp = wr & (adr_i == `HHSD_OFS_ALP);
  assign wr_pfb = wr & (adr_i == `HHSD_OFS_PFB);

  // ==========================================================
  // registers
  logic [7:0]  itc_r;
  logic        db_r;
  logic        ase_r;
  logic        pse_r;
  logic        aaf_r;
  logic        ien_r;
  logic [31:0] alp_r;
  logic [31:0] pfb_r;
  logic [31:0] cmd_w;
  logic [31:0] cmd_view;
  logic [31:0] sts_view;
  logic [31:0] ien_view;
  hhsd_db_e    db_state_r;
  hhsd_db_e    db_state_nxt;

  always_comb begin
    cmd_view = 32'h0000_0000;
    cmd_view[`HHSD_CMD_ITC_HI:`HHSD_CMD_ITC_LO] = itc_r;
    cmd_view[`HHSD_CMD_DB]  = db_r;
    cmd_view[`HHSD_CMD_ASE] = ase_r;
    cmd_view[`HHSD_CMD_PSE] = pse_r;
    sts_view = 32'h0000_0000;
    sts_view[`HHSD_STS_AAF] = aaf_r;
    ien_view = 32'h0000_0000;
    ien_view[`HHSD_STS_AAF] = ien_r;
  end

  assign cmd_w = (cmd_view & ~wmask) | (dat_i & wmask);

  assign rd_data = (adr_i == `HHSD_OFS_CMD) ? cmd_view :
                   (adr_i == `HHSD_OFS_STS) ? sts_view :
                   (adr_i == `HHSD_OFS_IEN) ? ien_view :
                   (adr_i == `HHSD_OFS_ALP) ? alp_r :
                   (adr_i == `HHSD_OFS_PFB) ? pfb_r : 32'h0000_0000;

  // unmapped addresses still get ack, read zero, drop writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc & ~ack_r;
      dat_r <= rd_data;
    end
  end

  // ==========================================================
  // schedule enables and pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ase_r <= 1'b0;
      pse_r <= 1'b0;
      itc_r <= `HHSD_ITC_RST;
      alp_r <= 32'h0000_0000;
      pfb_r <= 32'h0000_0000;
      ien_r <= 1'b0;
    end else begin
      if (wr_cmd) begin
        ase_r <= cmd_w[`HHSD_CMD_ASE];
        pse_r <= cmd_w[`HHSD_CMD_PSE];
        itc_r <= cmd_w[`HHSD_CMD_ITC_HI:`HHSD_CMD_ITC_LO];
      end
      if (wr_alp) alp_r <= ((alp_r & ~wmask) | (dat_i & wmask)) & `HHSD_ALP_MASK;
      if (wr_pfb) pfb_r <= ((pfb_r & ~wmask) | (dat_i & wmask)) & `HHSD_PFB_MASK;
      if (wr_ien) ien_r <= sel_i[0] ? dat_i[`HHSD_STS_AAF] : ien_r;
    end
  end

  // the engine gates every list walk on the enables; pointers stay readable while off
  assign sched_o = '{async_en:      ase_r,
                     periodic_en:   pse_r,
                     async_addr:    alp_r,
                     periodic_base: pfb_r};

  // ==========================================================
  // doorbell sequence
  logic ring;
  logic evicted;
  logic flush_r;

  assign ring    = wr_cmd & cmd_w[`HHSD_CMD_DB];
  assign evicted = (db_state_r == DB_FLUSH) & evict_done_i;

  always_comb begin
    case (db_state_r)
      DB_IDLE:  db_state_nxt = ring ? DB_FLUSH : DB_IDLE;
      DB_FLUSH: db_state_nxt = evict_done_i ? DB_CLEAR : DB_FLUSH;
      DB_CLEAR: db_state_nxt = DB_IDLE;
      default:  db_state_nxt = DB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_state_r <= DB_IDLE;
      flush_r    <= 1'b0;
      db_r       <= 1'b0;
    end else begin
      db_state_r <= db_state_nxt;
      flush_r    <= (db_state_nxt == DB_FLUSH);
      if (ring)
        db_r <= 1'b1;
      else if (db_state_r == DB_CLEAR)
        db_r <= 1'b0;
    end
  end

  // flag: hardware set beats a same-cycle software clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      aaf_r <= 1'b0;
    else if (evicted)
      aaf_r <= 1'b1;
    else if (wr_sts & sel_i[0] & dat_i[`HHSD_STS_AAF])
      aaf_r <= 1'b0;
  end

  // ==========================================================
  // micro frame timer and interrupt threshold
  localparam int UFC = `HHSD_UFRAME_CYC;
  logic [11:0] uf_cnt_r;
  logic [7:0]  thr_cnt_r;
  logic        uf_tick;
  logic        boundary;
  logic        pend;
  logic        irq_r;

  assign uf_tick  = (uf_cnt_r == 12'(UFC - 1));
  // a reserved zero threshold acts as one micro frame
  assign boundary = uf_tick & ((thr_cnt_r + 8'h01) >= itc_r);
  assign pend     = aaf_r & ien_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uf_cnt_r  <= 12'h000;
      thr_cnt_r <= 8'h00;
      irq_r     <= 1'b0;
    end else begin
      uf_cnt_r <= uf_tick ? 12'h000 : uf_cnt_r + 12'h001;
      if (boundary)
        thr_cnt_r <= 8'h00;
      else if (uf_tick)
        thr_cnt_r <= thr_cnt_r + 8'h01;
      if (!pend)
        irq_r <= 1'b0;
      else if (boundary)
        irq_r <= 1'b1;
    end
  end

  assign ack_o       = ack_r;
  assign dat_o       = dat_r;
  assign irq_o       = irq_r;
  assign flush_req_o = flush_r;

  // ==========================================================
  // assertions
  sequence s_ring;
    ring && db_state_r == DB_IDLE;
  endsequence

  sequence s_evict;
    db_state_r == DB_FLUSH && evict_done_i;
  endsequence

  property p_ring_flush;
    @(posedge clk_i) disable iff (rst_i) s_ring |=> flush_req_o && db_r;
  endproperty
  a_ring_flush: assert property (p_ring_flush) else $error("doorbell did not start flush");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) s_evict |=> aaf_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after eviction");

  property p_db_clear;
    @(posedge clk_i) disable iff (rst_i) s_evict ##1 !ring |=> !db_r;
  endproperty
  a_db_clear: assert property (p_db_clear) else $error("doorbell not cleared");

  property p_db_order;
    @(posedge clk_i) disable iff (rst_i) $fell(db_r) |-> aaf_r || $past(aaf_r);
  endproperty
  a_db_order: assert property (p_db_order) else $error("doorbell cleared before flag");

  property p_irq_boundary;
    @(posedge clk_i) disable iff (rst_i) $rose(irq_o) |-> $past(boundary) && $past(pend);
  endproperty
  a_irq_boundary: assert property (p_irq_boundary) else $error("irq off boundary");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      aaf_r && !(wr_sts && dat_i[`HHSD_STS_AAF] && sel_i[0]) |=> aaf_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_sched_en;
    @(posedge clk_i) disable iff (rst_i)
      wr_cmd |=> sched_o.async_en == $past(cmd_w[`HHSD_CMD_ASE])
             && sched_o.periodic_en == $past(cmd_w[`HHSD_CMD_PSE]);
  endproperty
  a_sched_en: assert property (p_sched_en) else $error("enable not taken");

  property p_rst_val;
    @(posedge clk_i) rst_i |=> !sched_o.async_en && !sched_o.periodic_en && itc_r == `HHSD_ITC_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset values");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
endmodule // hhsd_top
`default_nettype wire

// ==== test/hhsd_engine_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// schedule engine: evicts cached state some cycles after a flush request
module hhsd_engine_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       flush_req_i,
  input  wire logic [7:0] delay_i,
  output logic            evict_done_o
);
  logic [7:0] wait_r;
  // delay 0 answers one cycle after the request is first seen; larger values model a slow engine
  always_ff @(posedge clk_i) begin
    if (rst_i || !flush_req_i) begin
      wait_r       <= 8'h00;
      evict_done_o <= 1'b0;
    end else begin
      wait_r       <= wait_r + 8'h01;
      evict_done_o <= (wait_r == delay_i);
    end
  end
endmodule // hhsd_engine_model
`default_nettype wire

// ==== test/hhsd_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hhsd_defs.svh"
module hhsd_top_tb
  import hhsd_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack_o, evict, flush, irq_o;
  logic [7:0]  adr, delay;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, rd;
  hhsd_sched_s sched_o;
  int          err_count, checks, cyc_cnt, n;
  hhsd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .evict_done_i(evict), .flush_req_o(flush), .sched_o(sched_o), .irq_o(irq_o));
  hhsd_engine_model ENG (.clk_i(clk_i), .rst_i(rst_i), .flush_req_i(flush),
    .delay_i(delay), .evict_done_o(evict));
  // ==========================================================
  // clock, timeout, shared tasks
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is seen high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    // only the bench timeout ends this wait
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; sel <= 4'h0;
    // outputs launched on the ack edge are only looked at once settled
    @(negedge clk_i);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task automatic wait_flag();
    n = 0;
    do @(negedge clk_i); while (flush !== 1'b0 && ++n < 300);
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    do @(negedge clk_i); while (irq_o !== 1'b1 && ++n < lim);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("flush", {31'h0, flush}, 32'h0000_0000);
    chk("irq", {31'h0, irq_o}, 32'h0000_0000);
    chk("en", {30'h0, sched_o.async_en, sched_o.periodic_en}, 32'h0000_0000);
    rchk("cmd", `HHSD_OFS_CMD, 32'h0008_0000);
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0000);
    rchk("unmapped", 8'h20, 32'h0000_0000);
  endtask
  task automatic t_sched();
    wb(1'b1, `HHSD_OFS_CMD, 32'h0008_0010);
    chk("en", {30'h0, sched_o.async_en, sched_o.periodic_en}, 32'h0000_0001);
    wb(1'b1, `HHSD_OFS_CMD, 32'h0008_0030);
    chk("en", {30'h0, sched_o.async_en, sched_o.periodic_en}, 32'h0000_0003);
    wb(1'b1, `HHSD_OFS_ALP, 32'hFFFF_FFFF);
    rchk("alp", `HHSD_OFS_ALP, 32'hFFFF_FFE0);
    chk("aaddr", sched_o.async_addr, 32'hFFFF_FFE0);
    wb(1'b1, `HHSD_OFS_PFB, 32'hFFFF_FFFF);
    rchk("pfb", `HHSD_OFS_PFB, 32'hFFFF_F000);
    chk("pbase", sched_o.periodic_base, 32'hFFFF_F000);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h20, 32'h0000_0000);
  endtask
  // slow engine, interrupt enabled, default threshold of eight micro frames
  task automatic t_ring();
    delay <= 8'h10;
    wb(1'b1, `HHSD_OFS_IEN, 32'h0000_0020);
    wb(1'b1, `HHSD_OFS_CMD, 32'h0008_0070);
    chk("flush", {31'h0, flush}, 32'h0000_0001);
    rchk("db", `HHSD_OFS_CMD, 32'h0008_0070);
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0000);
    wait_flag();
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0020);
    chk("irq", {31'h0, irq_o}, 32'h0000_0000);
    rchk("db", `HHSD_OFS_CMD, 32'h0008_0030);
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0020);
    wait_irq(20100);
    chk("irq", {31'h0, irq_o}, 32'h0000_0001);
    wb(1'b1, `HHSD_OFS_STS, 32'h0000_0020);
    @(negedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h0000_0000);
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0000);
  endtask
  // prompt engine, masked then unmasked, threshold of one micro frame
  task automatic t_mask();
    delay <= 8'h00;
    wb(1'b1, `HHSD_OFS_IEN, 32'h0000_0000);
    wb(1'b1, `HHSD_OFS_CMD, 32'h0001_0070);
    wait_flag();
    repeat (3000) @(negedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h0000_0000);
    rchk("sts", `HHSD_OFS_STS, 32'h0000_0020);
    wb(1'b1, `HHSD_OFS_IEN, 32'h0000_0020);
    wait_irq(2600);
    chk("irq", {31'h0, irq_o}, 32'h0000_0001);
    wb(1'b1, `HHSD_OFS_STS, 32'h0000_0020);
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0000_0000;
    delay = 8'h00; err_count = 0; checks = 0; cyc_cnt = 0;
    sel = 4'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sched();
    t_ring();
    t_mask();
    end_of_test();
  end
endmodule // hhsd_top_tb
`default_nettype wire
